// ---- core/cell_balancer_defines.vh ----
// constants shared by the cell balancer telemetry remote terminal
`ifndef CELL_BALANCER_DEFINES_VH
`define CELL_BALANCER_DEFINES_VH

// ----------------------------------------------------------------------------
// subaddresses that carry single analog telemetry items
// ----------------------------------------------------------------------------
`define SA_TLM_A 5'd18
`define SA_TLM_B 5'd19
`define SA_TLM_C 5'd22

// ----------------------------------------------------------------------------
// request codes (first data word of the receive command)
// ----------------------------------------------------------------------------
`define CODE_REF_4V 16'h0800
`define CODE_REF_0V 16'h0803
`define CODE_TBV_1 16'h0805
`define CODE_TBV_2 16'h0806
`define CODE_TBV_3 16'h0809
`define CODE_SHARE_BUS 16'h080a
`define CODE_BYP_DRV 16'h080c
`define CODE_CELL_1 16'h0811
`define CODE_CELL_2 16'h0812
`define CODE_CELL_3 16'h0814
`define CODE_CELL_4 16'h0817
`define CODE_CELL_5 16'h0818
`define CODE_CELL_6 16'h081b
`define CODE_CELL_7 16'h081d
`define CODE_CELL_8 16'h081e
`define CODE_CELL_9 16'h0821
`define CODE_CELL_10 16'h0822
`define CODE_CELL_11 16'h0824
`define CODE_CELL_12 16'h0827
`define CODE_CELL_MIN 16'h0871
`define CODE_CELL_MAX 16'h0872
`define CODE_STATUS 16'h0c80

// ----------------------------------------------------------------------------
// item indices into the reply word table
// ----------------------------------------------------------------------------
`define IDX_REF_4V 5'd0
`define IDX_CELL_1 5'd7
`define IDX_CELL_MIN 5'd19
`define IDX_CELL_MAX 5'd20
`define IDX_STATUS 5'd21
`define NUM_ITEMS 22
`define NUM_INPUT_CH 19
`define NUM_CELLS 12

// ----------------------------------------------------------------------------
// reply word layout
// ----------------------------------------------------------------------------
`define RESULT_LSB 4
`define STATUS_OV_LATCH_BIT 13

// ----------------------------------------------------------------------------
// timing and threshold
// ----------------------------------------------------------------------------
`define MCLK_PERIOD_NS 4
`define REQ_DELAY_NS 1200000
`define REQ_DELAY_CYCLES ((`REQ_DELAY_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define OV_LATCH_MS 50
`define OV_LATCH_CYCLES ((`OV_LATCH_MS * 1000000) / `MCLK_PERIOD_NS)
`define OV_TRIP_LEVEL 12'hdc0

`endif

// ---- core/cell_balancer_telemetry_rt.v ----
// telemetry request and reply logic of the twelve cell balancer remote terminal
`timescale 1ns/100ps
`default_nettype none
`include "cell_balancer_defines.vh"

module cell_balancer_telemetry_rt #(
    parameter W = 12,
    parameter DELAY_CYCLES = `REQ_DELAY_CYCLES,
    parameter CNT_W = 20,
    parameter OV_TRIP_LEVEL = `OV_TRIP_LEVEL
) (
    input wire mclk,
    input wire rst_n,
    input wire [4:0] rt_addr_strap,
    output reg [4:0] rt_addr_q,
    output reg rt_addr_valid_q,
    input wire rx_valid,
    input wire rx_bus,
    input wire [4:0] rx_subaddr,
    input wire [15:0] rx_data,
    input wire reset_mode_cmd,
    input wire tx_req,
    input wire [4:0] tx_subaddr,
    output reg tx_valid_q,
    output reg [15:0] tx_data_q,
    output reg last_bus_q,
    input wire [`NUM_INPUT_CH*W-1:0] chan_data,
    output reg overvoltage_protect_latch_q
);

    // ------------------------------------------------------------------------
    // address straps
    // ------------------------------------------------------------------------
    reg [4:0] strap_meta_q;
    reg [4:0] strap_sync_q;
    reg [1:0] strap_wait_q;

    // straps come off a connector: two flops, then caught once after release
    always @(posedge mclk) begin
        if (!rst_n) begin
            strap_meta_q <= 5'h00;
            strap_sync_q <= 5'h00;
            strap_wait_q <= 2'h0;
            rt_addr_q <= 5'h00;
            rt_addr_valid_q <= 1'b0;
        end else begin
            strap_meta_q <= rt_addr_strap;
            strap_sync_q <= strap_meta_q;
            if (strap_wait_q != 2'h3) begin
                strap_wait_q <= strap_wait_q + 2'h1;
            end else if (!rt_addr_valid_q) begin
                rt_addr_q <= strap_sync_q;
                rt_addr_valid_q <= 1'b1;
            end
        end
    end

    // which redundant bus carried the latest request, for housekeeping only
    always @(posedge mclk) begin
        if (!rst_n) begin
            last_bus_q <= 1'b0;
        end else if (rx_valid) begin
            last_bus_q <= rx_bus;
        end
    end

    // ------------------------------------------------------------------------
    // cell extremes and overvoltage latch
    // ------------------------------------------------------------------------
    wire [W-1:0] cell_min;
    wire [W-1:0] cell_max;

    cell_min_max #(
        .N(`NUM_CELLS),
        .W(W)
    ) u_min_max (
        .mclk(mclk),
        .rst_n(rst_n),
        .cell_data(chan_data[`NUM_INPUT_CH*W-1:`IDX_CELL_1*W]),
        .min_q(cell_min),
        .max_q(cell_max)
    );

    // only the highest cell is compared; trip lands two cycles after the sample
    wire ov_trip = (cell_max >= OV_TRIP_LEVEL[W-1:0]);

    // set wins over a reset mode command in the same cycle
    always @(posedge mclk) begin
        if (!rst_n) begin
            overvoltage_protect_latch_q <= 1'b0;
        end else if (ov_trip) begin
            overvoltage_protect_latch_q <= 1'b1;
        end else if (reset_mode_cmd) begin
            overvoltage_protect_latch_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // reply word table
    // ------------------------------------------------------------------------
    wire [`NUM_ITEMS*16-1:0] words;

    genvar c;
    generate
        for (c = 0; c < `NUM_INPUT_CH; c = c + 1) begin : g_word
            assign words[c*16 +: 16] = {chan_data[c*W +: W], {`RESULT_LSB{1'b0}}};
        end
    endgenerate

    assign words[`IDX_CELL_MIN*16 +: 16] = {cell_min, {`RESULT_LSB{1'b0}}};
    assign words[`IDX_CELL_MAX*16 +: 16] = {cell_max, {`RESULT_LSB{1'b0}}};
    assign words[`IDX_STATUS*16 +: 16] = {2'b00, overvoltage_protect_latch_q, {`STATUS_OV_LATCH_BIT{1'b0}}};

    // ------------------------------------------------------------------------
    // request code decode
    // ------------------------------------------------------------------------
    // returns {known, index}; unknown codes fall through with known low
    function [5:0] decode;
        input [15:0] code;
        begin
            case (code)
                `CODE_REF_4V: decode = {1'b1, 5'd0};
                `CODE_REF_0V: decode = {1'b1, 5'd1};
                `CODE_TBV_1: decode = {1'b1, 5'd2};
                `CODE_TBV_2: decode = {1'b1, 5'd3};
                `CODE_TBV_3: decode = {1'b1, 5'd4};
                `CODE_SHARE_BUS: decode = {1'b1, 5'd5};
                `CODE_BYP_DRV: decode = {1'b1, 5'd6};
                `CODE_CELL_1: decode = {1'b1, 5'd7};
                `CODE_CELL_2: decode = {1'b1, 5'd8};
                `CODE_CELL_3: decode = {1'b1, 5'd9};
                `CODE_CELL_4: decode = {1'b1, 5'd10};
                `CODE_CELL_5: decode = {1'b1, 5'd11};
                `CODE_CELL_6: decode = {1'b1, 5'd12};
                `CODE_CELL_7: decode = {1'b1, 5'd13};
                `CODE_CELL_8: decode = {1'b1, 5'd14};
                `CODE_CELL_9: decode = {1'b1, 5'd15};
                `CODE_CELL_10: decode = {1'b1, 5'd16};
                `CODE_CELL_11: decode = {1'b1, 5'd17};
                `CODE_CELL_12: decode = {1'b1, 5'd18};
                `CODE_CELL_MIN: decode = {1'b1, `IDX_CELL_MIN};
                `CODE_CELL_MAX: decode = {1'b1, `IDX_CELL_MAX};
                `CODE_STATUS: decode = {1'b1, `IDX_STATUS};
                default: decode = 6'h00;
            endcase
        end
    endfunction

    wire [5:0] rx_dec = decode(rx_data);

    // ------------------------------------------------------------------------
    // request slots, one per telemetry subaddress
    // ------------------------------------------------------------------------
    wire [15:0] slot_res [0:2];
    wire [2:0] slot_tx_hit;

    genvar s;
    generate
        for (s = 0; s < 3; s = s + 1) begin : g_slot
            wire [4:0] sa = (s == 0) ? `SA_TLM_A : ((s == 1) ? `SA_TLM_B : `SA_TLM_C);
            wire rx_hit = rx_valid && (rx_subaddr == sa);
            reg [4:0] sel_q;
            reg known_q;
            reg busy_q;
            reg [CNT_W-1:0] cnt_q;
            reg [15:0] res_q;

            // a new request restarts the wait; result frozen only when it runs out
            always @(posedge mclk) begin
                if (!rst_n) begin
                    sel_q <= 5'h00;
                    known_q <= 1'b0;
                    busy_q <= 1'b0;
                    cnt_q <= {CNT_W{1'b0}};
                    res_q <= 16'h0000;
                end else if (rx_hit) begin
                    sel_q <= rx_dec[4:0];
                    known_q <= rx_dec[5];
                    busy_q <= 1'b1;
                    cnt_q <= DELAY_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
                end else if (busy_q) begin
                    if (cnt_q == {CNT_W{1'b0}}) begin
                        busy_q <= 1'b0;
                        res_q <= known_q ? words[sel_q*16 +: 16] : 16'h0000;
                    end else begin
                        cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
            end

            assign slot_res[s] = res_q;
            assign slot_tx_hit[s] = (tx_subaddr == sa);
        end
    endgenerate

    // ------------------------------------------------------------------------
    // transmit reply
    // ------------------------------------------------------------------------
    // an early fetch simply sees the previous completed result of that slot
    always @(posedge mclk) begin
        if (!rst_n) begin
            tx_valid_q <= 1'b0;
            tx_data_q <= 16'h0000;
        end else begin
            tx_valid_q <= tx_req;
            if (tx_req) begin
                if (slot_tx_hit[0]) begin
                    tx_data_q <= slot_res[0];
                end else if (slot_tx_hit[1]) begin
                    tx_data_q <= slot_res[1];
                end else if (slot_tx_hit[2]) begin
                    tx_data_q <= slot_res[2];
                end else begin
                    tx_data_q <= 16'h0000;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ---- core/cell_min_max.v ----
// lowest and highest of the twelve cell voltage samples
`timescale 1ns/100ps
`default_nettype none

module cell_min_max #(
    parameter N = 12,
    parameter W = 12
) (
    input wire mclk,
    input wire rst_n,
    input wire [N*W-1:0] cell_data,
    output reg [W-1:0] min_q,
    output reg [W-1:0] max_q
);

    // ------------------------------------------------------------------------
    // comparison chain
    // ------------------------------------------------------------------------
    wire [W-1:0] lo [0:N-1];
    wire [W-1:0] hi [0:N-1];

    assign lo[0] = cell_data[W-1:0];
    assign hi[0] = cell_data[W-1:0];

    // one compare stage per cell after the first; a tree would be shorter but timing is loose here
    genvar i;
    generate
        for (i = 1; i < N; i = i + 1) begin : g_stage
            wire [W-1:0] v = cell_data[i*W +: W];
            assign lo[i] = (v < lo[i-1]) ? v : lo[i-1];
            assign hi[i] = (v > hi[i-1]) ? v : hi[i-1];
        end
    endgenerate

    // registered extremes
    always @(posedge mclk) begin
        if (!rst_n) begin
            min_q <= {W{1'b0}};
            max_q <= {W{1'b0}};
        end else begin
            min_q <= lo[N-1];
            max_q <= hi[N-1];
        end
    end

endmodule

`default_nettype wire

// ---- testbench/bus_ctrl_model.sv ----
// bus controller model issuing single-word telemetry requests and fetches
`timescale 1ns/100ps
`default_nettype none
module bus_ctrl_model #(
    parameter int DELAY_CYCLES = 20
) (
    input wire logic mclk,
    output logic rx_valid,
    output logic rx_bus,
    output logic [4:0] rx_subaddr,
    output logic [15:0] rx_data,
    output logic reset_mode_cmd,
    output logic tx_req,
    output logic [4:0] tx_subaddr,
    input wire logic tx_valid_q,
    input wire logic [15:0] tx_data_q
);
    // idle bus until the first command
    initial begin
        rx_valid = 1'b0;
        rx_bus = 1'b0;
        rx_subaddr = 5'h00;
        rx_data = 16'h0000;
        reset_mode_cmd = 1'b0;
        tx_req = 1'b0;
        tx_subaddr = 5'h00;
    end
    // receive command with one code word; settle waits out the conversion
    task automatic request(input logic [4:0] sa, input logic [15:0] code, input logic bus, input logic settle);
        @(negedge mclk);
        rx_valid = 1'b1;
        rx_bus = bus;
        rx_subaddr = sa;
        rx_data = code;
        @(negedge mclk);
        rx_valid = 1'b0;
        rx_subaddr = ~sa;  // stale lines must not look like the old word
        rx_data = ~code;
        if (settle) repeat (DELAY_CYCLES + 2) @(negedge mclk);
    endtask
    // one-word transmit command, same subaddress as its request
    task automatic fetch(input logic [4:0] sa, output logic [15:0] data, output logic seen);
        @(negedge mclk);
        tx_req = 1'b1;
        tx_subaddr = sa;
        // the valid flag stands only for the cycle after the taking edge
        @(negedge mclk);
        seen = tx_valid_q;
        data = tx_data_q;
        tx_req = 1'b0;
        tx_subaddr = ~sa;
    endtask
    // reset mode command
    task automatic bus_reset();
        @(negedge mclk);
        reset_mode_cmd = 1'b1;
        @(negedge mclk);
        reset_mode_cmd = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- testbench/cell_balancer_telemetry_rt_asserts.sv ----
// port-level checks of the telemetry remote terminal
`timescale 1ns/100ps
`default_nettype none
`include "cell_balancer_defines.vh"
module cell_balancer_telemetry_rt_asserts #(
    parameter W = 12,
    parameter DELAY_CYCLES = 20,
    parameter CNT_W = 20,
    parameter OV_TRIP_LEVEL = 12'hdc0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [4:0] rt_addr_strap,
    input wire logic [4:0] rt_addr_q,
    input wire logic rt_addr_valid_q,
    input wire logic reset_mode_cmd,
    input wire logic tx_req,
    input wire logic [4:0] tx_subaddr,
    input wire logic tx_valid_q,
    input wire logic [15:0] tx_data_q,
    input wire logic [`NUM_INPUT_CH*W-1:0] chan_data,
    input wire logic overvoltage_protect_latch_q
);
    logic trip;
    // any cell at threshold means the highest one is; other channels never count
    always_comb begin
        trip = 1'b0;
        for (int c = 7; c < 19; c++) trip = trip | (chan_data[c*W +: W] >= OV_TRIP_LEVEL);
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_fetch_answer: assert property (tx_req |=> tx_valid_q)
        else $error("fetch not answered one cycle later");
    a_fetch_nocause: assert property (!tx_req |=> !tx_valid_q)
        else $error("reply valid without a fetch");
    a_reply_nibble: assert property (tx_valid_q |-> tx_data_q[3:0] == 4'h0)
        else $error("low nibble of reply not zero");
    a_bad_slot: assert property (tx_req && !(tx_subaddr inside {`SA_TLM_A, `SA_TLM_B, `SA_TLM_C})
        |=> tx_data_q == 16'h0000) else $error("foreign subaddress gave data");
    a_reply_hold: assert property (!tx_req |=> $stable(tx_data_q))
        else $error("reply word moved without a fetch");
    a_ov_trip: assert property (trip |-> ##2 overvoltage_protect_latch_q)
        else $error("overvoltage latch did not set");
    a_ov_quiet: assert property (!trip ##1 !overvoltage_protect_latch_q |=> !overvoltage_protect_latch_q)
        else $error("overvoltage latch set without a high cell");
    a_ov_hold: assert property (overvoltage_protect_latch_q && !reset_mode_cmd |=> overvoltage_protect_latch_q)
        else $error("overvoltage latch dropped by itself");
    a_ov_clear: assert property (!trip ##1 reset_mode_cmd |=> !overvoltage_protect_latch_q)
        else $error("bus reset did not clear the latch");
    // two sync flops plus the capture flop: the address seen now left the pins three edges ago
    a_addr_capture: assert property ($rose(rt_addr_valid_q) |-> rt_addr_q == $past(rt_addr_strap, 3))
        else $error("terminal address differs from straps");
    a_addr_keep: assert property (rt_addr_valid_q |=> rt_addr_valid_q && $stable(rt_addr_q))
        else $error("terminal address changed after capture");
endmodule
bind cell_balancer_telemetry_rt cell_balancer_telemetry_rt_asserts #(
    .W(W), .DELAY_CYCLES(DELAY_CYCLES), .CNT_W(CNT_W), .OV_TRIP_LEVEL(OV_TRIP_LEVEL)
) chk_u (
    .mclk(mclk), .rst_n(rst_n), .rt_addr_strap(rt_addr_strap), .rt_addr_q(rt_addr_q),
    .rt_addr_valid_q(rt_addr_valid_q), .reset_mode_cmd(reset_mode_cmd), .tx_req(tx_req),
    .tx_subaddr(tx_subaddr), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
    .chan_data(chan_data), .overvoltage_protect_latch_q(overvoltage_protect_latch_q)
);
`default_nettype wire

// ---- testbench/cell_balancer_telemetry_rt_tb.sv ----
// self-checking testbench for the telemetry remote terminal
`timescale 1ns/100ps
`default_nettype none
`include "cell_balancer_defines.vh"
module cell_balancer_telemetry_rt_tb;
    localparam int DLY = 20;
    localparam logic [4:0] STRAP = 5'h0b;
    localparam logic [4:0] SAS [3] = '{`SA_TLM_A, `SA_TLM_B, `SA_TLM_C};
    localparam logic [15:0] CODES [21] = '{16'h0800, 16'h0803, 16'h0805, 16'h0806, 16'h0809, 16'h080a, 16'h080c,
        16'h0811, 16'h0812, 16'h0814, 16'h0817, 16'h0818, 16'h081b, 16'h081d, 16'h081e, 16'h0821, 16'h0822,
        16'h0824, 16'h0827, 16'h0871, 16'h0872};
    logic mclk, rst_n, rt_addr_valid_q, rx_valid, rx_bus, reset_mode_cmd, tx_req, tx_valid_q, last_bus_q;
    logic overvoltage_protect_latch_q;
    logic [4:0] rt_addr_strap, rt_addr_q, rx_subaddr, tx_subaddr;
    logic [15:0] rx_data, tx_data_q;
    logic [`NUM_INPUT_CH*12-1:0] chan_data;
    logic [11:0] mn, mx;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    cell_balancer_telemetry_rt #(.DELAY_CYCLES(DLY)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .rt_addr_strap(rt_addr_strap), .rt_addr_q(rt_addr_q),
        .rt_addr_valid_q(rt_addr_valid_q), .rx_valid(rx_valid), .rx_bus(rx_bus), .rx_subaddr(rx_subaddr),
        .rx_data(rx_data), .reset_mode_cmd(reset_mode_cmd), .tx_req(tx_req), .tx_subaddr(tx_subaddr),
        .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q), .last_bus_q(last_bus_q), .chan_data(chan_data),
        .overvoltage_protect_latch_q(overvoltage_protect_latch_q));
    bus_ctrl_model #(.DELAY_CYCLES(DLY)) bc_u (
        .mclk(mclk), .rx_valid(rx_valid), .rx_bus(rx_bus), .rx_subaddr(rx_subaddr), .rx_data(rx_data),
        .reset_mode_cmd(reset_mode_cmd), .tx_req(tx_req), .tx_subaddr(tx_subaddr), .tx_valid_q(tx_valid_q),
        .tx_data_q(tx_data_q));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard, well above the roughly 660 cycles the run needs
    initial begin
        forever begin
            @(posedge mclk);
            cyc++;
            if (cyc == 8000) begin
                error_cnt++;
                finish_test();
            end
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic fetch_chk(input logic [4:0] sa, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        bc_u.fetch(sa, d, v);
        check(16'(v), 16'h0001);
        check(d, exp);
    endtask
    // power cycle: straps are stable before release, captured a few edges later
    task automatic do_reset();
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        repeat (5) @(negedge mclk);
        check(16'(rt_addr_q), 16'(STRAP));
        check(16'(rt_addr_valid_q), 16'h0001);
        check(16'(tx_valid_q), 16'h0000);
    endtask
    // every listed code, rotated over the three subaddresses and both buses
    task automatic t_codes();
        logic [11:0] e;
        mn = 12'hfff;
        mx = 12'h000;
        for (int c = 7; c < 19; c++) begin
            mn = (chan_data[c*12 +: 12] < mn) ? chan_data[c*12 +: 12] : mn;
            mx = (chan_data[c*12 +: 12] > mx) ? chan_data[c*12 +: 12] : mx;
        end
        for (int i = 0; i < 21; i++) begin
            bc_u.request(SAS[i % 3], CODES[i], i[0], 1'b1);
            check(16'(last_bus_q), 16'(i[0]));
            e = (i < 19) ? chan_data[i*12 +: 12] : ((i == 19) ? mn : mx);
            fetch_chk(SAS[i % 3], {e, 4'h0});
        end
    endtask
    // slots kept apart; early fetch, unknown code and foreign subaddress
    task automatic t_slots();
        bc_u.request(`SA_TLM_A, `CODE_CELL_3, 1'b0, 1'b0);
        bc_u.request(`SA_TLM_B, 16'h0123, 1'b1, 1'b0);
        fetch_chk(`SA_TLM_A, {chan_data[18*12 +: 12], 4'h0});
        repeat (DLY) @(negedge mclk);
        fetch_chk(`SA_TLM_A, {chan_data[9*12 +: 12], 4'h0});
        fetch_chk(`SA_TLM_B, 16'h0000);
        fetch_chk(`SA_TLM_C, {mx, 4'h0});
        fetch_chk(5'd20, 16'h0000);
    endtask
    // latch on the highest cell only, cleared by bus reset and by power cycle
    task automatic t_overvoltage();
        chan_data[2*12 +: 12] = 12'hfff;  // a high battery total must not trip
        chan_data[10*12 +: 12] = `OV_TRIP_LEVEL - 12'h001;
        repeat (4) @(negedge mclk);
        check(16'(overvoltage_protect_latch_q), 16'h0000);
        chan_data[10*12 +: 12] = `OV_TRIP_LEVEL;
        repeat (2) @(negedge mclk);
        check(16'(overvoltage_protect_latch_q), 16'h0001);
        chan_data[10*12 +: 12] = 12'h300;
        bc_u.request(`SA_TLM_C, `CODE_STATUS, 1'b0, 1'b1);
        fetch_chk(`SA_TLM_C, 16'h2000);
        check(16'(overvoltage_protect_latch_q), 16'h0001);
        bc_u.bus_reset();
        @(negedge mclk);
        check(16'(overvoltage_protect_latch_q), 16'h0000);
        chan_data[15*12 +: 12] = 12'hfff;
        repeat (2) @(negedge mclk);
        check(16'(overvoltage_protect_latch_q), 16'h0001);
        chan_data[15*12 +: 12] = 12'h300;
        do_reset();
        check(16'(overvoltage_protect_latch_q), 16'h0000);
    endtask
    // main sequence; samples distinct and out of order so min and max matter
    initial begin
        rst_n = 1'b0;
        rt_addr_strap = STRAP;
        for (int c = 0; c < 19; c++) chan_data[c*12 +: 12] = 12'h100 + 12'(c * 91 % 700);
        do_reset();
        t_codes();
        t_slots();
        t_overvoltage();
        finish_test();
    end
endmodule
`default_nettype wire
